//--- common/sst_consts.vh
// Constants for the split transfer host controller.
// Assumes a 100 MHz controller clock.
`ifndef SST_CONSTS_VH
`define SST_CONSTS_VH
// ****************************************
// Command codes on the user port
// ****************************************
`define SST_CMD_READ_XFER 3'h0
`define SST_CMD_MASK_WRITE_XFER 3'h1
`define SST_CMD_SPLIT_READ 3'h2
`define SST_CMD_SPLIT_WRITE 3'h3
`define SST_CMD_STOP_SET 3'h4
`define SST_CMD_REG_RESET 3'h5
`define SST_CMD_LAST_USER 3'h5
`define SST_CMD_DUMMY_RAS 3'h7
// ****************************************
// Pin levels at row strobe fall: {cas_first, wel_n, weu_n, dsf, trg_n}
// ****************************************
`define SST_LVL_READ_XFER 5'h0c
`define SST_LVL_MASK_WRITE 5'h00
`define SST_LVL_SPLIT_READ 5'h0e
`define SST_LVL_SPLIT_WRITE 5'h02
`define SST_LVL_STOP_SET 5'h13
`define SST_LVL_REG_RESET 5'h1d
`define SST_LVL_DUMMY_RAS 5'h0d
// ****************************************
// Timing
// ****************************************
`define SST_CLK_NS 10
`define SST_PAUSE_NS 200000
`define SST_STS_NS 30
`define SST_STEP_CYC 4'h4
`define SST_SC_HALF_CYC 4'h4
`define SST_DUMMY_COUNT 4'h8
`define SST_ADDR_W 9
`define SST_DATA_W 16
`define SST_STOP_LSB 4
`endif

//--- core/sst_host.v
// Host controller for a multiport DRAM with split serial transfers.
// Assumes direct pin wiring; flag and serial data are asynchronous.
`timescale 1ns/1ns
`default_nettype none
`include "sst_consts.vh"

// ****************************************
// Serial data FIFO
// ****************************************
module sst_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock_in,
    input wire srst_in,
    input wire ce_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    assign in_ready_out = (count_reg != DEPTH[AW:0]);
    assign out_valid_out = (count_reg != {(AW+1){1'b0}});
    assign out_data_out = mem_reg[rd_ptr_reg];
    assign push = in_valid_in & in_ready_out & ce_in;
    assign pop = out_valid_out & out_ready_in & ce_in;
    always @(posedge clock_in) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_in;
        end
    end
    always @(posedge clock_in) begin
        if (srst_in) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule // sst_fifo

// Behaviour
// - Split read: column strobe, write enables, special function high, transfer low.
// - Start split transfers only after the setup delay since the last flag toggle.
// - A conventional read transfer must precede any split read.
// - A masked write transfer must precede any split write.
// - Stop-set: column strobe low, a write enable low, special function high.
// - Register-reset: column strobe low, write enables high, special function low.
// - Hold row strobe and transfer enable high 200 us after power-up.
// - Then issue 8 dummy row strobe and 8 dummy serial clock cycles.
// - With internal refresh, use 8 column-before-row cycles instead; the code always issues row-strobe-only dummy cycles.
// - After initialisation, set a known state with a register-reset cycle.
// - Transfers need transfer enable low at row strobe fall; special function selects split.
module sst_host #(
    parameter PAUSE_CYC = `SST_PAUSE_NS / `SST_CLK_NS,
    parameter STS_NS = `SST_STS_NS,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire clock_in,
    input wire srst_in,
    input wire ce_in,
    input wire cmd_valid_in,
    output wire cmd_ready_out,
    input wire [2:0] cmd_code_in,
    input wire [`SST_ADDR_W-1:0] cmd_row_in,
    input wire [`SST_ADDR_W-1:0] cmd_col_in,
    input wire [`SST_DATA_W-1:0] cmd_mask_in,
    output reg cmd_error_out,
    output wire init_done_out,
    input wire serial_run_in,
    output wire rd_valid_out,
    input wire rd_ready_in,
    output wire [`SST_DATA_W-1:0] rd_data_out,
    output reg active_half_out,
    output reg ras_n_out,
    output reg cas_n_out,
    output reg transfer_output_enable_n_out,
    output reg write_enable_low_byte_n_out,
    output reg write_enable_high_byte_n_out,
    output reg special_function_select_out,
    output reg [`SST_ADDR_W-1:0] addr_out,
    output reg [`SST_DATA_W-1:0] dq_out,
    output reg dq_oe_out,
    output reg serial_shift_clock_out,
    input wire active_half_flag_in,
    input wire [`SST_DATA_W-1:0] serial_data_lines_in
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SET = 3'h1;
    localparam ST_RASL = 3'h2;
    localparam ST_CASL = 3'h3;
    localparam ST_TRGH = 3'h4;
    localparam ST_PRE = 3'h5;
    localparam IN_PAUSE = 2'h0;
    localparam IN_DUMMY = 2'h1;
    localparam IN_RESET = 2'h2;
    localparam IN_DONE = 2'h3;
    localparam [7:0] STS_CYC = (STS_NS + `SST_CLK_NS - 1) / `SST_CLK_NS;

    // Pin levels at row strobe fall
    function [4:0] sst_levels;
        input [2:0] code;
        begin
            case (code)
                `SST_CMD_READ_XFER: sst_levels = `SST_LVL_READ_XFER;
                `SST_CMD_MASK_WRITE_XFER: sst_levels = `SST_LVL_MASK_WRITE;
                `SST_CMD_SPLIT_READ: sst_levels = `SST_LVL_SPLIT_READ;
                `SST_CMD_SPLIT_WRITE: sst_levels = `SST_LVL_SPLIT_WRITE;
                `SST_CMD_STOP_SET: sst_levels = `SST_LVL_STOP_SET;
                `SST_CMD_REG_RESET: sst_levels = `SST_LVL_REG_RESET;
                default: sst_levels = `SST_LVL_DUMMY_RAS;
            endcase
        end
    endfunction

    reg [2:0] state_reg;
    reg [1:0] init_reg;
    reg [31:0] pause_cnt_reg;
    reg [3:0] step_cnt_reg;
    reg [3:0] ras_cnt_reg;
    reg [3:0] sc_cnt_reg;
    reg [3:0] sc_div_reg;
    reg [7:0] sts_cnt_reg;
    reg [2:0] code_reg;
    reg [`SST_ADDR_W-1:0] col_reg;
    reg read_done_reg;
    reg mask_write_done_reg;
    reg flag_meta_reg;
    reg flag_sync_reg;
    reg flag_last_reg;
    reg [`SST_DATA_W-1:0] sd_meta_reg;
    reg [`SST_DATA_W-1:0] sd_sync_reg;
    reg push_reg;
    reg [`SST_DATA_W-1:0] push_data_reg;
    wire fifo_ready;
    wire is_split;
    wire take;
    wire illegal;
    wire sc_run;
    wire [4:0] lv;

    assign init_done_out = (init_reg == IN_DONE);
    assign is_split = (cmd_code_in == `SST_CMD_SPLIT_READ) | (cmd_code_in == `SST_CMD_SPLIT_WRITE);
    assign cmd_ready_out = (state_reg == ST_IDLE) & init_done_out & ~(is_split & (sts_cnt_reg != 8'h00));
    assign take = cmd_valid_in & cmd_ready_out;
    assign illegal = (cmd_code_in > `SST_CMD_LAST_USER) |
                     ((cmd_code_in == `SST_CMD_SPLIT_READ) & ~read_done_reg) |
                     ((cmd_code_in == `SST_CMD_SPLIT_WRITE) & ~mask_write_done_reg);
    assign lv = sst_levels(code_reg);
    assign sc_run = ((init_reg == IN_DUMMY) & (sc_cnt_reg != `SST_DUMMY_COUNT)) |
                    (init_done_out & serial_run_in & fifo_ready);

    sst_fifo #(.WIDTH(`SST_DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .in_valid_in(push_reg),
        .in_ready_out(fifo_ready),
        .in_data_in(push_data_reg),
        .out_valid_out(rd_valid_out),
        .out_ready_in(rd_ready_in),
        .out_data_out(rd_data_out)
    );

    // ****************************************
    // Synchronisers, flag tracking and serial clock
    // ****************************************
    always @(posedge clock_in) begin
        if (srst_in) begin
            flag_meta_reg <= 1'b0;
            flag_sync_reg <= 1'b0;
            flag_last_reg <= 1'b0;
            sd_meta_reg <= {`SST_DATA_W{1'b0}};
            sd_sync_reg <= {`SST_DATA_W{1'b0}};
            active_half_out <= 1'b0;
            sts_cnt_reg <= 8'h00;
            serial_shift_clock_out <= 1'b0;
            sc_div_reg <= 4'h0;
            sc_cnt_reg <= 4'h0;
            push_reg <= 1'b0;
            push_data_reg <= {`SST_DATA_W{1'b0}};
        end else if (ce_in) begin
            flag_meta_reg <= active_half_flag_in;
            flag_sync_reg <= flag_meta_reg;
            flag_last_reg <= flag_sync_reg;
            sd_meta_reg <= serial_data_lines_in;
            sd_sync_reg <= sd_meta_reg;
            active_half_out <= flag_sync_reg;
            if (flag_sync_reg != flag_last_reg) begin
                sts_cnt_reg <= STS_CYC;
            end else if (sts_cnt_reg != 8'h00) begin
                sts_cnt_reg <= sts_cnt_reg - 8'h01;
            end
            push_reg <= 1'b0;
            if (!sc_run && !serial_shift_clock_out) begin
                sc_div_reg <= 4'h0;
            end else if (sc_div_reg == `SST_SC_HALF_CYC - 4'h1) begin
                sc_div_reg <= 4'h0;
                serial_shift_clock_out <= ~serial_shift_clock_out;
                if (serial_shift_clock_out && init_done_out) begin
                    push_reg <= 1'b1;
                    push_data_reg <= sd_sync_reg;
                end
                if (!serial_shift_clock_out && !init_done_out) begin
                    sc_cnt_reg <= sc_cnt_reg + 4'h1;
                end
            end else begin
                sc_div_reg <= sc_div_reg + 4'h1;
            end
        end
    end

    // ****************************************
    // Initialisation and strobe sequencer
    // ****************************************
    always @(posedge clock_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE;
            init_reg <= IN_PAUSE;
            pause_cnt_reg <= 32'h0;
            step_cnt_reg <= 4'h0;
            ras_cnt_reg <= 4'h0;
            code_reg <= `SST_CMD_DUMMY_RAS;
            col_reg <= {`SST_ADDR_W{1'b0}};
            read_done_reg <= 1'b0;
            mask_write_done_reg <= 1'b0;
            cmd_error_out <= 1'b0;
            ras_n_out <= 1'b1;
            cas_n_out <= 1'b1;
            transfer_output_enable_n_out <= 1'b1;
            write_enable_low_byte_n_out <= 1'b1;
            write_enable_high_byte_n_out <= 1'b1;
            special_function_select_out <= 1'b0;
            addr_out <= {`SST_ADDR_W{1'b0}};
            dq_out <= {`SST_DATA_W{1'b0}};
            dq_oe_out <= 1'b0;
        end else if (ce_in) begin
            cmd_error_out <= 1'b0;
            if (step_cnt_reg != 4'h0) begin
                step_cnt_reg <= step_cnt_reg - 4'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (init_reg == IN_PAUSE) begin
                        if (pause_cnt_reg == PAUSE_CYC - 1) begin
                            init_reg <= IN_DUMMY;
                        end else begin
                            pause_cnt_reg <= pause_cnt_reg + 32'h1;
                        end
                    end else if (init_reg == IN_DUMMY) begin
                        if (ras_cnt_reg != `SST_DUMMY_COUNT) begin
                            ras_cnt_reg <= ras_cnt_reg + 4'h1;
                            code_reg <= `SST_CMD_DUMMY_RAS;
                            state_reg <= ST_SET;
                        end else if (sc_cnt_reg == `SST_DUMMY_COUNT) begin
                            init_reg <= IN_RESET;
                        end
                    end else if (init_reg == IN_RESET) begin
                        code_reg <= `SST_CMD_REG_RESET;
                        init_reg <= IN_DONE;
                        state_reg <= ST_SET;
                    end else if (take) begin
                        if (illegal) begin
                            cmd_error_out <= 1'b1;
                        end else begin
                            code_reg <= cmd_code_in;
                            col_reg <= cmd_col_in;
                            addr_out <= cmd_row_in;
                            dq_out <= cmd_mask_in;
                            state_reg <= ST_SET;
                            if (cmd_code_in == `SST_CMD_READ_XFER) begin
                                read_done_reg <= 1'b1;
                            end
                            if (cmd_code_in == `SST_CMD_MASK_WRITE_XFER) begin
                                mask_write_done_reg <= 1'b1;
                            end
                        end
                    end
                end
                ST_SET: begin
                    cas_n_out <= ~lv[4];
                    write_enable_low_byte_n_out <= lv[3];
                    write_enable_high_byte_n_out <= lv[2];
                    special_function_select_out <= lv[1];
                    transfer_output_enable_n_out <= lv[0];
                    dq_oe_out <= ~lv[4] & ~lv[0] & ~(lv[3] & lv[2]);
                    step_cnt_reg <= `SST_STEP_CYC;
                    state_reg <= ST_RASL;
                end
                ST_RASL: begin
                    if (step_cnt_reg == 4'h0) begin
                        ras_n_out <= 1'b0;
                        step_cnt_reg <= `SST_STEP_CYC;
                        state_reg <= (lv[4] | lv[0]) ? ST_TRGH : ST_CASL;
                    end
                end
                ST_CASL: begin
                    if (step_cnt_reg == 4'h0) begin
                        addr_out <= col_reg;
                        cas_n_out <= 1'b0;
                        dq_oe_out <= 1'b0;
                        step_cnt_reg <= `SST_STEP_CYC;
                        state_reg <= ST_TRGH;
                    end
                end
                ST_TRGH: begin
                    if (step_cnt_reg == 4'h0) begin
                        transfer_output_enable_n_out <= 1'b1;
                        write_enable_low_byte_n_out <= 1'b1;
                        write_enable_high_byte_n_out <= 1'b1;
                        dq_oe_out <= 1'b0;
                        step_cnt_reg <= `SST_STEP_CYC;
                        state_reg <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    if (step_cnt_reg == 4'h0) begin
                        ras_n_out <= 1'b1;
                        cas_n_out <= 1'b1;
                        special_function_select_out <= 1'b0;
                        step_cnt_reg <= `SST_STEP_CYC;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // sst_host
`default_nettype wire

//--- tb/sst_props_properties.sv
// Checks on sst_host pins and command port.
// Assumes one clock domain and the level codes of sst_consts.vh.
`timescale 1ns/1ns
`default_nettype none
`include "sst_consts.vh"
module sst_props #(
    parameter PAUSE_CYC = 20
) (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_ready_out,
    input wire logic [2:0] cmd_code_in,
    input wire logic [`SST_ADDR_W-1:0] cmd_row_in,
    input wire logic cmd_error_out,
    input wire logic init_done_out,
    input wire logic ras_n_out,
    input wire logic cas_n_out,
    input wire logic transfer_output_enable_n_out,
    input wire logic write_enable_low_byte_n_out,
    input wire logic write_enable_high_byte_n_out,
    input wire logic special_function_select_out,
    input wire logic [`SST_ADDR_W-1:0] addr_out,
    input wire logic serial_shift_clock_out,
    input wire logic active_half_flag_in
);
    localparam int STS_CYC = 3;
    wire logic take = cmd_valid_in & cmd_ready_out;
    wire logic [4:0] lvl = {~cas_n_out, write_enable_low_byte_n_out, write_enable_high_byte_n_out,
        special_function_select_out, transfer_output_enable_n_out};
    logic [`SST_ADDR_W-1:0] row_reg;
    logic seen_rd_reg, seen_wr_reg, took_reg, flag_reg;
    int since_rst_reg, gap_reg, n_ras_reg, n_sc_reg;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // ****************************************
    // Helper state: counts and order flags
    // ****************************************
    always_ff @(posedge clock_in) begin
        flag_reg <= active_half_flag_in;
        if (take)
            row_reg <= cmd_row_in;
        if (srst_in) begin
            {seen_rd_reg, seen_wr_reg, took_reg} <= 3'h0;
            since_rst_reg <= 0;
            gap_reg <= 100;
            n_ras_reg <= 0;
            n_sc_reg <= 0;
        end else begin
            if (take)
                took_reg <= 1'b1;
            if (since_rst_reg < PAUSE_CYC)
                since_rst_reg <= since_rst_reg + 1;
            gap_reg <= (flag_reg != active_half_flag_in) ? 0 : (gap_reg < 100 ? gap_reg + 1 : gap_reg);
            if ($fell(ras_n_out))
                n_ras_reg <= n_ras_reg + 1;
            if ($rose(serial_shift_clock_out))
                n_sc_reg <= n_sc_reg + 1;
            if ($fell(ras_n_out) && lvl == `SST_LVL_READ_XFER)
                seen_rd_reg <= 1'b1;
            if ($fell(ras_n_out) && lvl == `SST_LVL_MASK_WRITE)
                seen_wr_reg <= 1'b1;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    a_pause_ras_high: assert property (!ras_n_out |-> since_rst_reg >= PAUSE_CYC)
        else $error("ras low in pause");
    a_trg_init_high: assert property (!init_done_out |-> transfer_output_enable_n_out)
        else $error("trg low in init");
    a_dummy_cycles_done: assert property ($rose(init_done_out) |-> n_ras_reg >= 8 && n_sc_reg >= 8)
        else $error("too few dummies");
    a_legal_pin_levels: assert property ($fell(ras_n_out) |-> lvl inside {`SST_LVL_READ_XFER,
        `SST_LVL_MASK_WRITE, `SST_LVL_SPLIT_READ, `SST_LVL_SPLIT_WRITE, `SST_LVL_STOP_SET,
        `SST_LVL_REG_RESET, `SST_LVL_DUMMY_RAS})
        else $error("bad pin levels");
    a_split_rd_order: assert property ($fell(ras_n_out) && lvl == `SST_LVL_SPLIT_READ |-> seen_rd_reg)
        else $error("split read order");
    a_split_wr_order: assert property ($fell(ras_n_out) && lvl == `SST_LVL_SPLIT_WRITE |-> seen_wr_reg)
        else $error("split write order");
    a_refuse_bad_split: assert property (take && ((cmd_code_in == `SST_CMD_SPLIT_READ && !seen_rd_reg)
        || (cmd_code_in == `SST_CMD_SPLIT_WRITE && !seen_wr_reg)) |-> ##[1:2] cmd_error_out)
        else $error("split not refused");
    a_split_setup_gap: assert property ($fell(ras_n_out) && lvl inside {`SST_LVL_SPLIT_READ,
        `SST_LVL_SPLIT_WRITE} |-> gap_reg >= STS_CYC)
        else $error("split too soon");
    a_row_addr_match: assert property ($fell(ras_n_out) && took_reg |-> addr_out == row_reg)
        else $error("row address wrong");
endmodule // sst_props

bind sst_host sst_props #(.PAUSE_CYC(PAUSE_CYC)) u_props (.*);
`default_nettype wire

//--- tb/sst_dram_model.sv
// DRAM model: transfers, stops, serial port.
// Assumes its pins come straight from sst_host, which also makes the serial clock.
`timescale 1ns/1ns
`default_nettype none
module sst_dram_model (
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic trg_n_in,
    input wire logic wel_n_in,
    input wire logic weu_n_in,
    input wire logic dsf_in,
    input wire logic [8:0] addr_in,
    input wire logic [15:0] dq_in,
    input wire logic sc_in,
    output logic half_out = 1'b0,
    output logic [15:0] sdq_out = 16'h0000
);
    logic [4:0] kind_reg = 5'h00;
    logic out_mode_reg = 1'b0;
    logic stops_reg = 1'b0;
    logic [8:0] part_reg = 9'h100;
    logic [8:0] ptr_reg = 9'h000;
    logic [8:0] tap_reg = 9'h100;
    logic [15:0] mask_reg = 16'h0000;
    int n_ras = 0;
    int n_sc = 0;
    wire logic [8:0] lim = (stops_reg ? part_reg : 9'h100) - 9'h001;
    always @(negedge ras_n_in) begin
        n_ras <= n_ras + 1;
        kind_reg <= {~cas_n_in, wel_n_in, weu_n_in, dsf_in, trg_n_in};
        if (!trg_n_in && !dsf_in)
            out_mode_reg <= wel_n_in & weu_n_in;
        if (!trg_n_in && !(wel_n_in & weu_n_in))
            mask_reg <= dq_in;
        if (!cas_n_in && dsf_in) begin
            stops_reg <= 1'b1;
            part_reg <= !addr_in[4] ? 9'h010 : !addr_in[5] ? 9'h020 : !addr_in[6] ? 9'h040 :
                !addr_in[7] ? 9'h080 : 9'h100;
        end
        if (!cas_n_in && !dsf_in && wel_n_in && weu_n_in)
            stops_reg <= 1'b0;
    end
    // Split tap goes to the idle half
    always @(negedge cas_n_in) begin
        if (!ras_n_in && !kind_reg[0]) begin
            if (kind_reg[1]) begin
                tap_reg <= {~half_out, addr_in[7:0]};
            end else begin
                ptr_reg <= addr_in;
                tap_reg <= {~addr_in[8], 8'h00};
                half_out <= addr_in[8];
            end
        end
    end
    // Input mode: undriven, toggle
    always @(posedge sc_in) begin
        n_sc <= n_sc + 1;
        sdq_out <= out_mode_reg ? {7'h00, ptr_reg} : ~sdq_out;
        if (({1'b0, ptr_reg[7:0]} & lim) == lim) begin
            ptr_reg <= tap_reg;
            tap_reg <= {ptr_reg[8], 8'h00};
            half_out <= ~half_out;
        end else begin
            ptr_reg <= ptr_reg + 9'h001;
        end
    end
endmodule // sst_dram_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for sst_host.
// Assumes a 100 MHz clock and a shortened power-up pause.
`timescale 1ns/1ns
`default_nettype none
`include "sst_consts.vh"
module tb_top;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_code = 3'h0;
    logic [8:0] cmd_row = 9'h000;
    logic [8:0] cmd_col = 9'h000;
    logic [15:0] cmd_mask = 16'h0000;
    logic serial_run = 1'b0;
    logic rd_ready = 1'b0;
    logic err_seen;
    wire logic cmd_ready, cmd_err, init_done, rd_valid, half, ras_n, cas_n, trg_n, wel_n, weu_n, special_function_select, dq_oe, sc, flag;
    wire logic [15:0] rd_data, dq, serial_data_lines;
    wire logic [8:0] addr;
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clock_in = ~clock_in;
    sst_host #(.PAUSE_CYC(20)) dut (.clock_in(clock_in), .srst_in(srst_in), .ce_in(1'b1),
        .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_code_in(cmd_code), .cmd_row_in(cmd_row),
        .cmd_col_in(cmd_col), .cmd_mask_in(cmd_mask), .cmd_error_out(cmd_err), .init_done_out(init_done),
        .serial_run_in(serial_run), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready), .rd_data_out(rd_data),
        .active_half_out(half), .ras_n_out(ras_n), .cas_n_out(cas_n), .transfer_output_enable_n_out(trg_n),
        .write_enable_low_byte_n_out(wel_n), .write_enable_high_byte_n_out(weu_n),
        .special_function_select_out(special_function_select), .addr_out(addr), .dq_out(dq), .dq_oe_out(dq_oe),
        .serial_shift_clock_out(sc), .active_half_flag_in(flag), .serial_data_lines_in(serial_data_lines));
    sst_dram_model model (.ras_n_in(ras_n), .cas_n_in(cas_n), .trg_n_in(trg_n), .wel_n_in(wel_n),
        .weu_n_in(weu_n), .dsf_in(special_function_select), .addr_in(addr), .dq_in(dq), .sc_in(sc), .half_out(flag), .sdq_out(serial_data_lines));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t mismatch: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            test_done;
        end
    end
    task tick;
        @(posedge clock_in);
        #1;
    endtask
    task wait_ready;
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 2000) begin
            tick;
            n++;
        end
    endtask
    // One command, held until taken
    task do_cmd(input logic [2:0] c, input logic [8:0] r, input logic [8:0] k, input logic [15:0] m);
        @(posedge clock_in);
        cmd_code <= c;
        cmd_row <= r;
        cmd_col <= k;
        cmd_mask <= m;
        cmd_valid <= 1'b1;
        #1;
        wait_ready;
        @(posedge clock_in);
        cmd_valid <= 1'b0;
        err_seen = 1'b0;
        #1;
        repeat (3) begin
            if (cmd_err === 1'b1)
                err_seen = 1'b1;
            tick;
        end
        wait_ready;
    endtask
    task t_init;
        wait_ready;
        check(init_done, 1'b1);
        check(model.n_ras >= 9, 1'b1);
        check(model.n_sc >= 8, 1'b1);
        check(model.kind_reg, `SST_LVL_REG_RESET);
        $display("test init finished");
    endtask
    task t_refuse;
        logic [2:0] bad [3] = '{`SST_CMD_SPLIT_READ, `SST_CMD_SPLIT_WRITE, 3'h7};
        int n0;
        for (int i = 0; i < 3; i++) begin
            n0 = model.n_ras;
            do_cmd(bad[i], 9'h001, 9'h002, 16'h0000);
            check(err_seen, 1'b1);
            check(model.n_ras, n0);
        end
        $display("test refuse finished");
    endtask
    task t_levels;
        logic [4:0] lvl [6] = '{`SST_LVL_READ_XFER, `SST_LVL_MASK_WRITE, `SST_LVL_SPLIT_READ,
            `SST_LVL_SPLIT_WRITE, `SST_LVL_STOP_SET, `SST_LVL_REG_RESET};
        for (int c = 0; c < 6; c++) begin
            do_cmd(3'(c), 9'h0a5, 9'h013, 16'h5a3c);
            check(err_seen, 1'b0);
            check(model.kind_reg, lvl[c]);
        end
        check(model.mask_reg, 16'h5a3c);
        check(model.out_mode_reg, 1'b0);
        check(model.stops_reg, 1'b0);
        $display("test levels finished");
    endtask
    task t_serial;
        logic [15:0] w [8];
        logic [15:0] e;
        int n, k;
        @(posedge clock_in);
        rd_ready <= 1'b1;
        repeat (40) tick;
        do_cmd(`SST_CMD_READ_XFER, 9'h000, 9'h0fa, 16'h0000);
        @(posedge clock_in);
        serial_run <= 1'b1;
        #1;
        k = 0;
        n = 0;
        while (k < 8 && n < 400) begin
            if (rd_valid === 1'b1) begin
                w[k] = rd_data;
                k++;
            end
            tick;
            n++;
        end
        @(posedge clock_in);
        serial_run <= 1'b0;
        e = 16'h00fa;
        for (int i = 0; i < 8; i++) begin
            check(w[i], e);
            e = (e == 16'h00ff) ? 16'h0100 : e + 16'h0001;
        end
        check(half, 1'b1);
        $display("test serial finished");
    endtask
    task t_fifo;
        int n;
        repeat (40) tick;
        @(posedge clock_in);
        rd_ready <= 1'b0;
        serial_run <= 1'b1;
        repeat (300) tick;
        n = 0;
        repeat (40) begin
            if (sc === 1'b1)
                n++;
            tick;
        end
        check(n, 0);
        @(posedge clock_in);
        serial_run <= 1'b0;
        rd_ready <= 1'b1;
        #1;
        n = 0;
        repeat (60) begin
            if (rd_valid === 1'b1)
                n++;
            tick;
        end
        check(n, 16);
        $display("test fifo finished");
    endtask
    task t_stops;
        logic [3:0] nib [5] = '{4'hf, 4'h7, 4'hb, 4'hd, 4'he};
        logic [8:0] size [5] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010};
        for (int i = 0; i < 5; i++) begin
            do_cmd(`SST_CMD_STOP_SET, {1'b1, nib[i], 4'h5}, 9'h000, 16'h0000);
            check(model.stops_reg, 1'b1);
            check(model.part_reg, size[i]);
        end
        do_cmd(`SST_CMD_REG_RESET, 9'h000, 9'h000, 16'h0000);
        check(model.stops_reg, 1'b0);
        $display("test stops finished");
    endtask
    initial begin
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        t_init;
        t_refuse;
        t_levels;
        t_serial;
        t_fifo;
        t_stops;
        test_done;
    end
endmodule // tb_top
`default_nettype wire
